/* core/fsg_pkg.sv */
// package for the flash sector guard host controller
// assumes a word-wide parallel flash on the far side and an apb master
// Functional notes
// (RULE1) flash lets protected sectors change while reset pin sits at high voltage
// (RULE2) dropping the high voltage re-protects formerly protected sectors
// (RULE3) boot guard pin low blocks changes to the two outermost boot sectors
// (RULE4) outermost boot sectors are lowest for bottom boot, highest for top
// (RULE5) boot guard pin high: those sectors follow their stored protect state
// (RULE6) id read: high voltage on id line, selects low, select line picks code
// (RULE7) protect verify: high voltage, query line high, sector on a12-a20
// (RULE8) flash offers an extra 64 kbyte security region beside the array
// (RULE9) lock indicator on q7 is fixed: 1 factory locked, 0 lockable
// (RULE10) after enter sequence, boot sector addresses read the security region
// (RULE11) security mapping lasts until exit, power loss or hardware reset
// (RULE12) factory locked security region refuses every program or erase
// (RULE13) serial number field is 16 bytes at bottom or top boot location
// (RULE14) unlocked lockable security region behaves like ordinary array space
// (RULE15) host locks region with three-cycle enter then the protect algorithm; host here issues the enter only and has no protect algorithm operation
// (RULE16) host must exit the security region before touching the main array
// (RULE17) once protected, the security region can never be unprotected
// (RULE18) flash starts in read mode at power-up
// (RULE19) flash changes contents only after a complete correct sequence
// (RULE20) wrong or out-of-order write aborts the sequence back to read mode
// (RULE21) a write happens only with select and strobe low, output gate high
// (RULE22) reset pin low aborts any operation and returns to array read
// (RULE23) target blocked when protected without override, or guard pin low; model blocks on guard low only in the two outermost boot sectors
// (RULE24) command to a blocked sector leaves data and returns to read mode
package fsg_pkg;
    localparam int CLK_NS = 50;
    localparam int T_ACC_NS = 90;
    localparam int T_WP_NS = 45;
    localparam int T_RP_NS = 500;
    localparam int T_RH_NS = 50;
    // least times round up
    localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RH_CYC = (T_RH_NS + CLK_NS - 1) / CLK_NS;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_PINS = 8'h14;
    localparam int PIN_GUARD = 0;
    localparam int PIN_HV = 1;
    localparam int PIN_TOP = 2;
    localparam logic [2:0] PINS_RST = 3'h1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_SEC = 1;
    localparam int STAT_ERR = 2;

    localparam logic [20:0] UNLOCK_A1 = 21'h000555;
    localparam logic [20:0] UNLOCK_A2 = 21'h0002aa;
    localparam logic [15:0] UNLOCK_D1 = 16'h00aa;
    localparam logic [15:0] UNLOCK_D2 = 16'h0055;
    localparam logic [15:0] CMD_ENTER = 16'h0088;
    localparam logic [15:0] CMD_AUTOSEL = 16'h0090;
    localparam logic [15:0] CMD_EXIT = 16'h0000;
    localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
    localparam logic [15:0] CMD_RESET = 16'h00f0;
    localparam logic [11:0] VERIFY_LOW = 12'h002;

    typedef enum logic [2:0] {
        OP_READ, OP_PROGRAM, OP_ENTER, OP_EXIT,
        OP_RESET_CMD, OP_ID_READ, OP_PROT_VERIFY, OP_HW_RESET
    } fsg_op_t;

    typedef enum logic [2:0] {
        S_IDLE, S_SETUP, S_ASSERT, S_STROBE, S_RELEASE,
        S_RST_LO, S_RST_HI, S_DONE
    } fsg_state_e_t;

    typedef struct packed {
        logic [20:0] addr;
        logic [15:0] dq_out;
        logic dq_oe;
        logic chip_select_n;
        logic output_gate_n;
        logic write_strobe_n;
        logic reset_n;
        logic reset_hv;
        logic id_trigger_address_line;
        logic boot_guard_accel_pin;
    } fsg_flash_t;

    typedef struct packed {
        logic [20:0] addr;
        logic [15:0] data;
        logic wr;
        logic last;
    } fsg_step_t;
endpackage

/* core/fsg_host.sv */
// host controller driving the flash protection and security pins
// assumes an apb master on pclk and a flash whose pins the bench resolves
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fsg_host
(
    input wire logic pclk, // 20 mhz clock
    input wire logic presetn, // async reset
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [15:0] dq_in, // flash data in
    output fsg_pkg::fsg_flash_t flash // flash pin drive
);
    import fsg_pkg::*;

    typedef struct packed {
        fsg_state_e_t st;
        fsg_op_t op;
        logic [2:0] step;
        logic [3:0] cnt;
        logic [20:0] uaddr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [2:0] pins;
        logic sec_mode;
        logic err;
        fsg_flash_t fl;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } fsg_regs_t;

    fsg_regs_t s;
    fsg_regs_t next_s;
    fsg_step_t stp;

    function automatic logic fsg_in_window(input logic [20:0] a,
                                           input logic top);
        // security region overlays the boot end of the map
        fsg_in_window = top ? (&a[20:15]) : ~(|a[20:15]);
    endfunction

    function automatic fsg_step_t fsg_cmd_step(input fsg_op_t op,
        input logic [2:0] idx, input logic [20:0] ua, input logic [15:0] wd);
        fsg_step_t r;
        r = '{addr: ua, data: wd, wr: 1'b0, last: 1'b1};
        unique case (op)
            OP_ENTER, OP_EXIT, OP_PROGRAM:
            begin
                r.wr = 1'b1;
                r.last = 1'b0;
                unique case (idx)
                    3'd0:
                    begin
                        r.addr = UNLOCK_A1;
                        r.data = UNLOCK_D1;
                    end
                    3'd1:
                    begin
                        r.addr = UNLOCK_A2;
                        r.data = UNLOCK_D2;
                    end
                    3'd2:
                    begin
                        r.addr = UNLOCK_A1;
                        r.data = (op == OP_ENTER) ? CMD_ENTER :
                            (op == OP_EXIT) ? CMD_AUTOSEL : CMD_PROGRAM;
                        r.last = (op == OP_ENTER);
                    end
                    default:
                    begin
                        r.data = (op == OP_EXIT) ? CMD_EXIT : wd;
                        r.last = 1'b1;
                    end
                endcase
            end
            OP_RESET_CMD:
            begin
                r.wr = 1'b1;
                r.data = CMD_RESET;
            end
            OP_ID_READ:
                r.addr = {20'h00000, ua[0]};
            OP_PROT_VERIFY:
                r.addr = {ua[20:12], VERIFY_LOW};
            default:
                r.wr = 1'b0;
        endcase
        return r;
    endfunction

    always_comb
    begin
        next_s = s;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
        stp = fsg_cmd_step(s.op, s.step, s.uaddr, s.wdata);
        if (psel && penable && !s.pready)
        begin
            next_s.pready = 1'b1;
            next_s.prdata = 32'h00000000;
            unique case (paddr)
                REG_CTRL:
                    if (pwrite)
                    begin
                        // refuse while busy, or a read or program outside the window in sec mode
                        if (s.st != S_IDLE || (s.sec_mode &&
                            (fsg_op_t'(pwdata[2:0]) == OP_READ ||
                             fsg_op_t'(pwdata[2:0]) == OP_PROGRAM) &&
                            !fsg_in_window(s.uaddr, s.pins[PIN_TOP]))) // RULE16
                            next_s.err = 1'b1;
                        else
                        begin
                            next_s.err = 1'b0;
                            next_s.op = fsg_op_t'(pwdata[2:0]);
                            next_s.step = 3'd0;
                            if (fsg_op_t'(pwdata[2:0]) == OP_HW_RESET)
                            begin
                                next_s.fl.reset_n = 1'b0;
                                next_s.cnt = 4'(RP_CYC - 1);
                                next_s.st = S_RST_LO;
                            end
                            else
                                next_s.st = S_SETUP;
                        end
                    end
                REG_ADDR:
                    if (pwrite)
                        next_s.uaddr = pwdata[20:0];
                    else
                        next_s.prdata = {11'h000, s.uaddr};
                REG_WDATA:
                    if (pwrite)
                        next_s.wdata = pwdata[15:0];
                    else
                        next_s.prdata = {16'h0000, s.wdata};
                REG_RDATA:
                    next_s.prdata = {16'h0000, s.rdata};
                REG_STATUS:
                    next_s.prdata = {29'h00000000, s.err, s.sec_mode,
                                     s.st != S_IDLE};
                REG_PINS:
                    if (pwrite)
                        next_s.pins = pwdata[2:0];
                    else
                        next_s.prdata = {29'h00000000, s.pins};
                default:
                    next_s.pslverr = 1'b1;
            endcase
        end
        // guard level and temporary unprotect voltage follow software
        next_s.fl.boot_guard_accel_pin = s.pins[PIN_GUARD];
        next_s.fl.reset_hv = s.pins[PIN_HV]; // RULE1
        unique case (s.st)
            S_IDLE:
                next_s.st = next_s.st;
            S_SETUP:
            begin
                next_s.fl.addr = stp.addr;
                next_s.fl.dq_out = stp.data;
                next_s.fl.dq_oe = stp.wr;
                next_s.fl.chip_select_n = 1'b0;
                next_s.fl.id_trigger_address_line =
                    (s.op == OP_ID_READ) || (s.op == OP_PROT_VERIFY); // RULE6
                next_s.st = S_ASSERT;
            end
            S_ASSERT:
            begin
                // gate stays high under a write strobe
                next_s.fl.write_strobe_n = !stp.wr; // RULE21
                next_s.fl.output_gate_n = stp.wr;
                next_s.cnt = stp.wr ? 4'(WP_CYC - 1) : 4'(ACC_CYC - 1);
                next_s.st = S_STROBE;
            end
            S_STROBE:
                if (s.cnt == 4'h0)
                begin
                    next_s.fl.write_strobe_n = 1'b1;
                    next_s.fl.output_gate_n = 1'b1;
                    if (!stp.wr)
                        next_s.rdata = dq_in;
                    next_s.st = S_RELEASE;
                end
                else
                    next_s.cnt = s.cnt - 4'h1;
            S_RELEASE:
            begin
                next_s.fl.chip_select_n = 1'b1;
                next_s.fl.dq_oe = 1'b0;
                next_s.fl.id_trigger_address_line = 1'b0;
                next_s.step = s.step + 3'd1;
                next_s.st = stp.last ? S_DONE : S_SETUP;
            end
            S_RST_LO:
                if (s.cnt == 4'h0)
                begin
                    next_s.fl.reset_n = 1'b1;
                    next_s.cnt = 4'(RH_CYC - 1);
                    next_s.st = S_RST_HI;
                end
                else
                    next_s.cnt = s.cnt - 4'h1;
            S_RST_HI:
                if (s.cnt == 4'h0)
                    next_s.st = S_DONE;
                else
                    next_s.cnt = s.cnt - 4'h1;
            S_DONE:
            begin
                // track which map the flash is showing
                if (s.op == OP_ENTER)
                    next_s.sec_mode = 1'b1; // RULE10
                else if (s.op == OP_EXIT || s.op == OP_HW_RESET)
                    next_s.sec_mode = 1'b0; // RULE16
                next_s.st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
            s.st <= S_IDLE;
            s.op <= OP_READ;
            s.pins <= PINS_RST;
            s.fl.chip_select_n <= 1'b1;
            s.fl.output_gate_n <= 1'b1;
            s.fl.write_strobe_n <= 1'b1;
            s.fl.reset_n <= 1'b1;
            s.fl.boot_guard_accel_pin <= 1'b1;
        end
        else
            s <= next_s;
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign flash = s.fl;

    property p_write_gate;
        @(posedge pclk) disable iff (!presetn)
        !s.fl.write_strobe_n |-> !s.fl.chip_select_n && s.fl.output_gate_n;
    endproperty
    a_write_gate: assert property (p_write_gate) // RULE21
        else $error("write strobe without select or with gate low");

    property p_id_pins;
        @(posedge pclk) disable iff (!presetn)
        (!s.fl.output_gate_n && s.op == OP_ID_READ) |->
            s.fl.id_trigger_address_line && !s.fl.addr[6] &&
            !s.fl.addr[1] && !s.fl.chip_select_n && s.fl.addr[0] == s.uaddr[0];
    endproperty
    a_id_pins: assert property (p_id_pins) // RULE6
        else $error("id read pins wrong");

    property p_prot_pins;
        @(posedge pclk) disable iff (!presetn)
        (!s.fl.output_gate_n && s.op == OP_PROT_VERIFY) |->
            s.fl.id_trigger_address_line && s.fl.write_strobe_n &&
            s.fl.addr[1] && !s.fl.addr[0] && !s.fl.addr[6] &&
            s.fl.addr[20:12] == s.uaddr[20:12];
    endproperty
    a_prot_pins: assert property (p_prot_pins) // RULE7
        else $error("protect verify pins wrong");

    property p_hv_scope;
        @(posedge pclk) disable iff (!presetn)
        s.fl.id_trigger_address_line |->
            (s.op == OP_ID_READ || s.op == OP_PROT_VERIFY) && s.fl.dq_oe == 1'b0;
    endproperty
    a_hv_scope: assert property (p_hv_scope) // RULE6
        else $error("high voltage on id line outside id or verify");

    property p_enter_third;
        @(posedge pclk) disable iff (!presetn)
        (!s.fl.write_strobe_n && s.op == OP_ENTER && s.step == 3'd2) |->
            s.fl.dq_out == CMD_ENTER && s.fl.addr == UNLOCK_A1;
    endproperty
    a_enter_third: assert property (p_enter_third) // RULE15
        else $error("enter sequence third write wrong");

    property p_enter_maps;
        @(posedge pclk) disable iff (!presetn)
        (s.st == S_DONE && s.op == OP_ENTER) |=> s.sec_mode && s.st == S_IDLE;
    endproperty
    a_enter_maps: assert property (p_enter_maps) // RULE10
        else $error("security mode not set after enter");

    property p_exit_unmaps;
        @(posedge pclk) disable iff (!presetn)
        (s.st == S_DONE && s.op == OP_EXIT) |=> !s.sec_mode;
    endproperty
    a_exit_unmaps: assert property (p_exit_unmaps) // RULE16
        else $error("security mode kept after exit");

    property p_refuse_outside;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !s.pready && pwrite && paddr == REG_CTRL &&
         s.st == S_IDLE && s.sec_mode && pwdata[2:0] == 3'(OP_READ) &&
         !fsg_in_window(s.uaddr, s.pins[PIN_TOP]))
        |=> s.err ##1 s.st == S_IDLE && s.fl.chip_select_n;
    endproperty
    a_refuse_outside: assert property (p_refuse_outside) // RULE16
        else $error("main array touched while in security mode");

    c_enter: cover property (@(posedge pclk) disable iff (!presetn)
        s.st == S_DONE && s.op == OP_ENTER);
    c_verify: cover property (@(posedge pclk) disable iff (!presetn)
        s.st == S_DONE && s.op == OP_PROT_VERIFY);
    c_hw_reset: cover property (@(posedge pclk) disable iff (!presetn)
        s.st == S_RST_HI ##1 s.st == S_DONE);
endmodule
`default_nettype wire

/* verif/fsg_flash_model.sv */
// behavioural parallel flash facing the sector guard host
// assumes host pins arrive as the package struct; no electrical timing
`timescale 1ns/1ps
`default_nettype none
module fsg_flash_model
#(
    parameter bit TOP = 1'h0, // boot layout
    parameter bit FACTORY_LOCKED = 1'h0, // security lock kind
    parameter logic [15:0] MAKER = 16'h005a, // arbitrary value
    parameter logic [15:0] DEVICE = 16'h3c3c // arbitrary value
)
(
    input wire fsg_pkg::fsg_flash_t flash, // pins from host
    output logic [15:0] dq // data pins to host
);
    import fsg_pkg::*;
    logic [15:0] mem [logic [21:0]]; // bit 21 picks the security region
    bit [511:0] prot;
    int seq;
    int wcnt;
    bit sec;
    logic [15:0] rd;
    logic [15:0] d;
    logic [20:0] a;
    // lock indicator sits on bit 7 and never changes
    localparam logic [7:0] LOCK_CODE = {FACTORY_LOCKED, 7'h19};

    function automatic bit in_win(logic [20:0] x);
        return TOP ? &x[20:15] : ~|x[20:15];
    endfunction
    function automatic logic [21:0] key(logic [20:0] x);
        return {sec && in_win(x), x};
    endfunction
    function automatic bit blocked(logic [20:0] x);
        if (sec && in_win(x))
            return FACTORY_LOCKED;
        return (prot[x[20:12]] && !flash.reset_hv)
            || (!flash.boot_guard_accel_pin
            && x[20:13] == (TOP ? 8'hff : 8'h00));
    endfunction

    initial
    begin
        seq = 0;
        sec = 0;
        wcnt = 0;
        prot = '0;
        prot[2] = 1'h1; // one sector group starts protected
        for (int i = 0; i < 8; i++)
            mem[{1'h1, (TOP ? 21'h1f8000 : 21'h0) + 21'(i)}] =
                16'h5e00 + 16'(i);
    end

    always @(posedge flash.write_strobe_n or negedge flash.reset_n)
    begin
        a = flash.addr;
        d = flash.dq_out;
        if (!flash.reset_n)
        begin
            seq = 0;
            sec = 0;
        end
        else if (!flash.chip_select_n && flash.output_gate_n)
        begin
            case (seq)
                0: seq = (a == UNLOCK_A1 && d == UNLOCK_D1) ? 1 : 0;
                1: seq = (a == UNLOCK_A2 && d == UNLOCK_D2) ? 2 : 0;
                2:
                begin
                    seq = a != UNLOCK_A1 ? 0 : d == CMD_AUTOSEL ? 3 :
                        d == CMD_PROGRAM ? 4 : 0;
                    if (a == UNLOCK_A1 && d == CMD_ENTER)
                        sec = 1;
                end
                3:
                begin
                    if (d == CMD_EXIT)
                        sec = 0;
                    seq = 0;
                end
                default:
                begin
                    if (!blocked(a))
                        mem[key(a)] = d;
                    seq = 0;
                end
            endcase
            wcnt++;
        end
    end

    always @(flash or sec or wcnt)
        if (flash.id_trigger_address_line)
            rd = flash.addr[1:0] == 2'b11 ? {8'h00, LOCK_CODE}
                : flash.addr[1] ? {15'h0, prot[flash.addr[20:12]]}
                : flash.addr[0] ? DEVICE : MAKER;
        else
            rd = mem.exists(key(flash.addr)) ? mem[key(flash.addr)] : 16'hffff;

    // released bus shows the inverse so a stale value cannot pass
    assign dq = (!flash.chip_select_n && !flash.output_gate_n
        && flash.reset_n) ? rd : ~rd;
endmodule
`default_nettype wire

/* verif/tb_fsg_host.sv */
// self-checking bench for the sector guard host over apb
// assumes the behavioural flash model on the pins; one 20 mhz clock
`timescale 1ns/1ps
`default_nettype none
module tb_fsg_host;
    import fsg_pkg::*;
    localparam logic [15:0] MAKER = 16'h005a; // arbitrary value
    localparam logic [15:0] DEVICE = 16'h3c3c; // arbitrary value
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] dq_in;
    logic [15:0] dq_open;
    logic [15:0] dq_lock;
    logic use_lock = 1'h0;
    fsg_flash_t flash;
    logic [31:0] r;
    logic e;
    int fail_count = 0;
    int checks = 0;
    logic [20:0] ta [4] = '{21'h0, 21'h1, 21'h002000, 21'h003000};
    logic [15:0] te [4] = '{MAKER, DEVICE, 16'h1, 16'h0};

    always #25 pclk = ~pclk;

    fsg_host i_fsg_host (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dq_in(dq_in),
        .flash(flash));
    fsg_flash_model #(.MAKER(MAKER), .DEVICE(DEVICE)) i_fsg_flash_model
        (.flash(flash), .dq(dq_open));
    // second part with a factory-locked security region on the same pins
    fsg_flash_model #(.FACTORY_LOCKED(1'h1), .MAKER(MAKER), .DEVICE(DEVICE))
        i_fsg_flash_model_locked (.flash(flash), .dq(dq_lock));
    assign dq_in = use_lock ? dq_lock : dq_open;

    task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
            fail_count++;
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // no limit here: only the watchdog ends a stuck access
        do
            @(posedge pclk);
        while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic run(logic [20:0] a, logic [15:0] d, fsg_op_t op);
        int n;
        apb(1'h1, REG_ADDR, {11'h0, a});
        apb(1'h1, REG_WDATA, {16'h0, d});
        apb(1'h1, REG_CTRL, {29'h0, op});
        n = 0;
        do
        begin
            apb(1'h0, REG_STATUS, 32'h0);
            n++;
        end
        while (r[STAT_BUSY] !== 1'h0 && n < 100);
        // an operation still busy after the poll limit counts as a mismatch
        chk("busy cleared", {31'h0, r[STAT_BUSY]}, 32'h0);
    endtask

    task automatic rdw(logic [20:0] a);
        run(a, 16'h0, OP_READ);
        apb(1'h0, REG_RDATA, 32'h0);
    endtask

    task automatic prog(logic [20:0] a, logic [15:0] d, logic [15:0] x);
        run(a, d, OP_PROGRAM);
        rdw(a);
        chk($sformatf("word %h", a), r, {16'h0, x});
    endtask

    initial
    begin
        #(50 * 20000);
        fail_count++;
        stop_test();
    end

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, REG_PINS, 32'h0);
        chk("pins reset", r, {29'h0, PINS_RST});
        apb(1'h0, REG_STATUS, 32'h0);
        chk("status reset", r, 32'h0);
        apb(1'h0, 8'h20, 32'h0);
        chk("unmapped", {31'h0, e}, 32'h1);
        $display("test registers done");
        prog(21'h003010, 16'h1234, 16'h1234);
        prog(21'h002010, 16'h1234, 16'hffff);
        for (int i = 0; i < 4; i++)
        begin
            run(ta[i], 16'h0, i < 2 ? OP_ID_READ : OP_PROT_VERIFY);
            apb(1'h0, REG_RDATA, 32'h0);
            chk("id or verify", r, {16'h0, te[i]});
        end
        $display("test program and id done");
        apb(1'h1, REG_PINS, 32'h3);
        repeat (2) @(negedge pclk);
        chk("hv pin", {31'h0, flash.reset_hv}, 32'h1);
        prog(21'h002020, 16'h00a5, 16'h00a5);
        apb(1'h1, REG_PINS, 32'h1);
        prog(21'h002030, 16'h00a5, 16'hffff);
        apb(1'h1, REG_PINS, 32'h0);
        prog(21'h000100, 16'h0077, 16'hffff);
        prog(21'h001100, 16'h0077, 16'hffff);
        apb(1'h1, REG_PINS, 32'h1);
        prog(21'h000100, 16'h0077, 16'h0077);
        $display("test protection done");
        run(21'h0, 16'h0, OP_ENTER);
        chk("enter", r, 32'h2);
        rdw(21'h0);
        chk("serial", r, 32'h5e00);
        prog(21'h000010, 16'h0abc, 16'h0abc);
        run(21'h100000, 16'h0, OP_READ);
        chk("outside window", r, 32'h6);
        run(21'h0, 16'h0, OP_EXIT);
        chk("exit", {31'h0, r[STAT_SEC]}, 32'h0);
        rdw(21'h000010);
        chk("array again", r, 32'hffff);
        run(21'h0, 16'h0, OP_ENTER);
        run(21'h0, 16'h0, OP_HW_RESET);
        chk("hw reset", {31'h0, r[STAT_SEC]}, 32'h0);
        rdw(21'h000010);
        chk("boot map after reset", r, 32'hffff);
        use_lock <= 1'h1;
        run(21'h0, 16'h0, OP_ENTER);
        prog(21'h0, 16'h1111, 16'h5e00);
        run(21'h0, 16'h0, OP_EXIT);
        $display("test security done");
        stop_test();
    end
endmodule
`default_nettype wire
